// *** rtl/lnac_accept_timer.sv ***
// lnac_accept_timer: slot counter that rejects an unanswered incoming request
`timescale 1ns/1ps
`default_nettype none
module lnac_accept_timer #(
   parameter int unsigned SLOT_CYCLES = lnac_pkg::SLOT_CYC
) (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        conn_req,
   input  wire logic        conn_accept,
   input  wire logic [15:0] limit,
   output wire logic        conn_reject,
   output wire logic        pending
);
   localparam logic [12:0] CYC_LAST = 13'(SLOT_CYCLES - 1);
   typedef struct packed {
      logic [12:0] cyc;
      logic [15:0] slots;
      logic [15:0] limit;
      logic        busy;
      logic        reject;
   } lnac_tmr_st_t;
   lnac_tmr_st_t s_q, s_d;
   // slot count runs from the request; a new request restarts it
   always_comb begin
      s_d = s_q;
      s_d.reject = 1'b0;
      if (s_q.busy) begin
         s_d.cyc = s_q.cyc + 13'h0001;
         if (s_q.cyc == CYC_LAST) begin
            s_d.cyc = '0;
            s_d.slots = s_q.slots + 16'h0001;
            if (s_d.slots == s_q.limit) begin
               s_d.busy = 1'b0;
               s_d.reject = 1'b1;
            end
         end
      end
      if (conn_accept) begin
         s_d.busy = 1'b0;
         s_d.reject = 1'b0;
      end
      if (conn_req) begin
         s_d = '0;
         s_d.busy = 1'b1;
         s_d.limit = limit;
      end
   end
   always_ff @(posedge clock) begin
      if (rst) s_q <= '0;
      else s_q <= s_d;
   end
   assign conn_reject = s_q.reject;
   assign pending     = s_q.busy;
   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   chk_expire_time:
      assert property (s_q.busy && s_q.cyc == CYC_LAST && s_q.slots + 16'h0001 == s_q.limit
                       && !conn_req && !conn_accept |=> s_q.reject && !s_q.busy)
      else $error("timeout did not expire after limit slots");
   chk_reject_cause:
      assert property ($rose(s_q.reject) |-> $past(s_q.busy) && $past(s_q.cyc) == CYC_LAST)
      else $error("reject without an expired pending request");
   cov_reject: cover property (s_q.reject);
endmodule : lnac_accept_timer
`default_nettype wire

// *** rtl/lnac_evt_irq.sv ***
// lnac_evt_irq: sticky event status, mask and level interrupt
`timescale 1ns/1ps
`default_nettype none
module lnac_evt_irq (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic [1:0] evt_set,
   input  wire logic       stat_clr_we,
   input  wire logic       mask_we,
   input  wire logic [1:0] wdata,
   output wire logic [1:0] stat,
   output wire logic [1:0] mask,
   output wire logic       irq
);
   typedef struct packed {
      logic [1:0] stat;
      logic [1:0] mask;
      logic       irq;
   } lnac_evt_st_t;
   lnac_evt_st_t s_q, s_d;
   // write one clears; a set in the same cycle wins
   always_comb begin
      s_d = s_q;
      s_d.stat = (s_q.stat & ~(stat_clr_we ? wdata : 2'h0)) | evt_set;
      if (mask_we) s_d.mask = wdata;
      s_d.irq = |(s_d.stat & s_d.mask);
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         s_q <= '0;
         s_q.mask <= lnac_pkg::EVT_MASK_RST;
      end else begin
         s_q <= s_d;
      end
   end
   assign stat = s_q.stat;
   assign mask = s_q.mask;
   assign irq  = s_q.irq;
   chk_set_wins:
      assert property (@(posedge clock) disable iff (rst)
                       |evt_set |=> (s_q.stat & $past(evt_set)) == $past(evt_set))
      else $error("event lost against a clear");
endmodule : lnac_evt_irq
`default_nettype wire

// *** rtl/lnac_name_tmo_ctl.sv ***
// lnac_name_tmo_ctl: command interpreter for name, key delete and accept timeout
`timescale 1ns/1ps
`default_nettype none
module lnac_name_tmo_ctl #(
   parameter int unsigned SLOT_CYCLES = lnac_pkg::SLOT_CYC
) (
   input  wire logic                    clock,
   input  wire logic                    rst,
   input  wire lnac_pkg::lnac_av_req_t  av_req,
   output wire lnac_pkg::lnac_av_rsp_t  av_rsp,
   input  wire logic                    conn_req,
   input  wire logic                    conn_accept,
   output wire logic                    conn_reject,
   output wire lnac_pkg::lnac_key_req_t key_req,
   input  wire lnac_pkg::lnac_key_rsp_t key_rsp,
   output wire logic                    irq
);
   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   typedef struct packed {
      lnac_pkg::lnac_cmd_st_t  st;
      logic                    ack;
      logic                    waitreq;
      logic [31:0]             rdata;
      logic [9:0]              opc;
      logic [15:0]             param;
      logic [7:0]              status;
      logic [15:0]             rval;
      logic [15:0]             tmo;
      logic [7:0]              idx;
      logic                    bank;
      logic                    empty;
      lnac_pkg::lnac_key_req_t key;
      logic                    done;
   } lnac_top_st_t;

   lnac_top_st_t s_q, s_d;

   logic        req;
   logic        acc_wr;
   logic        acc_rd;
   logic        name_step;
   logic        name_we;
   logic [7:0]  name_byte;
   logic [31:0] rd_word;
   logic [1:0]  evt_set;
   logic [1:0]  evt_stat;
   logic [1:0]  evt_mask;
   logic        evt_clr_we;
   logic        evt_mask_we;
   logic        tmr_reject;
   logic        tmr_pending;

   // two name banks: one is stored, the other fills from the bus
   logic [7:0]  name_mem [2][lnac_pkg::NAME_LEN];

   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   // address decode shared by reads, writes and side effects
   function automatic logic hit(
      input logic [7:0] addr,
      input logic [7:0] off
   );
      hit = (addr == off);
   endfunction : hit

   // accept timeout range check
   function automatic logic tmo_ok(input logic [15:0] v);
      tmo_ok = (v >= lnac_pkg::TMO_MIN) && (v <= lnac_pkg::TMO_MAX);
   endfunction : tmo_ok

   // -------------------------------------------------------------
   // bus strobes
   // -------------------------------------------------------------
   // the request is acted on at the edge where waitrequest is seen low
   assign req       = av_req.read | av_req.write;
   assign acc_wr    = s_q.ack & av_req.write;
   assign acc_rd    = s_q.ack & av_req.read;
   assign name_step = s_q.ack & hit(av_req.address, lnac_pkg::REG_NAME_DATA)
                      & (s_q.idx <= lnac_pkg::NAME_LAST);
   assign name_we   = name_step & av_req.write;
   assign evt_clr_we  = acc_wr & hit(av_req.address, lnac_pkg::REG_EVT_STAT);
   assign evt_mask_we = acc_wr & hit(av_req.address, lnac_pkg::REG_EVT_MASK);

   // stored name byte, zero while the name is still the reset default
   always_comb begin
      name_byte = 8'h00;
      if (!s_q.empty && s_q.idx <= lnac_pkg::NAME_LAST) begin
         name_byte = name_mem[s_q.bank][s_q.idx];
      end
   end

   // event sources: command completion and automatic reject
   always_comb begin
      evt_set = 2'h0;
      evt_set[lnac_pkg::EVT_DONE_BIT] = s_q.done;
      evt_set[lnac_pkg::EVT_REJ_BIT]  = tmr_reject;
   end

   // -------------------------------------------------------------
   // read multiplexer
   // -------------------------------------------------------------
   always_comb begin
      rd_word = 32'h0000_0000;
      case (av_req.address)
         lnac_pkg::REG_CMD: begin
            rd_word[9:0] = s_q.opc;
         end
         lnac_pkg::REG_PARAM: begin
            rd_word[15:0] = s_q.param;
         end
         lnac_pkg::REG_RESULT: begin
            rd_word[7:0] = s_q.status;
            rd_word[lnac_pkg::RES_BUSY_BIT] = (s_q.st != lnac_pkg::CS_IDLE);
            rd_word[lnac_pkg::RES_PEND_BIT] = tmr_pending;
            rd_word[lnac_pkg::RES_VAL_LSB +: 16] = s_q.rval;
         end
         lnac_pkg::REG_NAME_IDX: begin
            rd_word[7:0] = s_q.idx;
         end
         lnac_pkg::REG_NAME_DATA: begin
            rd_word[7:0] = name_byte;
         end
         lnac_pkg::REG_TMO: begin
            rd_word[15:0] = s_q.tmo;
         end
         lnac_pkg::REG_EVT_STAT: begin
            rd_word[1:0] = evt_stat;
         end
         lnac_pkg::REG_EVT_MASK: begin
            rd_word[1:0] = evt_mask;
         end
         default: begin
            rd_word = 32'h0000_0000;
         end
      endcase
   end

   // -------------------------------------------------------------
   // next state: bus slave, then command sequencer
   // -------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      s_d.key.req = 1'b0;
      // one wait cycle, then a single-cycle answer
      s_d.ack = req & ~s_q.ack;
      s_d.waitreq = ~s_d.ack;
      if (s_d.ack && av_req.read) s_d.rdata = rd_word;
      // plain register writes
      if (acc_wr && hit(av_req.address, lnac_pkg::REG_PARAM)) begin
         s_d.param = av_req.writedata[15:0];
      end
      if (acc_wr && hit(av_req.address, lnac_pkg::REG_NAME_IDX)) begin
         s_d.idx = av_req.writedata[7:0];
      end
      // name bytes go first character first at rising index
      if (name_step) s_d.idx = s_q.idx + 8'h01;
      case (s_q.st)
         lnac_pkg::CS_IDLE: begin
            if (acc_wr && hit(av_req.address, lnac_pkg::REG_CMD)) begin
               s_d.opc = av_req.writedata[9:0];
               s_d.st  = lnac_pkg::CS_EXEC;
            end
         end
         lnac_pkg::CS_EXEC: begin
            s_d.status = lnac_pkg::ST_OK;
            s_d.rval   = 16'h0000;
            s_d.st     = lnac_pkg::CS_DONE;
            case (s_q.opc)
               lnac_pkg::OPC_DEL_KEY: begin
                  if (s_q.param[7:0] > lnac_pkg::DEL_ALL_MAX) begin
                     s_d.status = lnac_pkg::ST_BAD_PARAM;
                  end else begin
                     s_d.key.req = 1'b1;
                     s_d.key.all = s_q.param[0];
                     s_d.st = lnac_pkg::CS_WAIT;
                  end
               end
               lnac_pkg::OPC_SET_NAME: begin
                  s_d.bank  = ~s_q.bank;
                  s_d.empty = 1'b0;
               end
               lnac_pkg::OPC_GET_NAME: begin
                  s_d.idx = 8'h00;
               end
               lnac_pkg::OPC_GET_TMO: begin
                  s_d.rval = s_q.tmo;
               end
               lnac_pkg::OPC_SET_TMO: begin
                  if (tmo_ok(s_q.param)) begin
                     s_d.tmo = s_q.param;
                  end else begin
                     s_d.status = lnac_pkg::ST_BAD_PARAM;
                  end
               end
               default: begin
                  s_d.status = lnac_pkg::ST_UNKNOWN;
               end
            endcase
         end
         lnac_pkg::CS_WAIT: begin
            if (key_rsp.done) begin
               s_d.rval = key_rsp.count;
               s_d.st   = lnac_pkg::CS_DONE;
            end
         end
         lnac_pkg::CS_DONE: begin
            s_d.done = 1'b1;
            s_d.st   = lnac_pkg::CS_IDLE;
         end
         default: begin
            s_d.st = lnac_pkg::CS_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge clock) begin
      if (rst) begin
         s_q <= '0;
         s_q.waitreq <= 1'b1;
         s_q.tmo <= lnac_pkg::TMO_RST;
         s_q.empty <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // staging bank fills while the other bank stays readable
   always_ff @(posedge clock) begin
      if (name_we) name_mem[~s_q.bank][s_q.idx] <= av_req.writedata[7:0];
   end

   // -------------------------------------------------------------
   // sub-blocks
   // -------------------------------------------------------------
   lnac_accept_timer #(
      .SLOT_CYCLES (SLOT_CYCLES)
   ) u_timer (
      .clock       (clock),
      .rst         (rst),
      .conn_req    (conn_req),
      .conn_accept (conn_accept),
      .limit       (s_q.tmo),
      .conn_reject (tmr_reject),
      .pending     (tmr_pending)
   );

   lnac_evt_irq u_evt (
      .clock       (clock),
      .rst         (rst),
      .evt_set     (evt_set),
      .stat_clr_we (evt_clr_we),
      .mask_we     (evt_mask_we),
      .wdata       (av_req.writedata[1:0]),
      .stat        (evt_stat),
      .mask        (evt_mask),
      .irq         (irq)
   );

   // outputs straight from flops
   assign av_rsp.readdata    = s_q.rdata;
   assign av_rsp.waitrequest = s_q.waitreq;
   assign key_req            = s_q.key;
   assign conn_reject        = tmr_reject;

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   chk_key_count:
      assert property (s_q.st == lnac_pkg::CS_WAIT && key_rsp.done
                       |=> s_q.rval == $past(key_rsp.count) ##1 s_q.done)
      else $error("deleted key count not returned");

   chk_done_event:
      assert property (s_q.st == lnac_pkg::CS_DONE && evt_mask[lnac_pkg::EVT_DONE_BIT]
                       |=> ##1 evt_stat[lnac_pkg::EVT_DONE_BIT] && irq)
      else $error("command complete event missing");

   chk_name_commit:
      assert property (s_q.st == lnac_pkg::CS_EXEC && s_q.opc == lnac_pkg::OPC_SET_NAME
                       |=> s_q.bank != $past(s_q.bank) && !s_q.empty)
      else $error("set name did not commit the staged name");

   chk_name_order:
      assert property (name_step && s_q.st != lnac_pkg::CS_EXEC
                       |=> s_q.idx == $past(s_q.idx) + 8'h01)
      else $error("name index did not advance");

   chk_name_reset:
      assert property ($fell(rst) |-> s_q.empty && name_byte == 8'h00)
      else $error("name not empty after reset");

   chk_bad_opcode:
      assert property (s_q.st == lnac_pkg::CS_EXEC && s_q.opc > lnac_pkg::OPC_SET_TMO
                       |=> s_q.status == lnac_pkg::ST_UNKNOWN)
      else $error("unknown command not refused");

   chk_name_read:
      assert property (av_req.read && hit(av_req.address, lnac_pkg::REG_NAME_DATA)
                       && !s_q.ack && s_q.empty |=> s_q.rdata == 32'h0000_0000)
      else $error("empty name read not zero");

   chk_tmo_read:
      assert property (s_q.st == lnac_pkg::CS_EXEC && s_q.opc == lnac_pkg::OPC_GET_TMO
                       |=> s_q.rval == $past(s_q.tmo) && s_q.status == lnac_pkg::ST_OK)
      else $error("timeout read returned wrong value");

   chk_tmo_write:
      assert property (s_q.st == lnac_pkg::CS_EXEC && s_q.opc == lnac_pkg::OPC_SET_TMO
                       && tmo_ok(s_q.param) |=> s_q.tmo == $past(s_q.param))
      else $error("valid timeout not stored");

   chk_tmo_reject:
      assert property (s_q.st == lnac_pkg::CS_EXEC && s_q.opc == lnac_pkg::OPC_SET_TMO
                       && !tmo_ok(s_q.param)
                       |=> $stable(s_q.tmo) && s_q.status == lnac_pkg::ST_BAD_PARAM)
      else $error("invalid timeout accepted");

   chk_tmo_reset:
      assert property ($fell(rst) |-> s_q.tmo == lnac_pkg::TMO_RST)
      else $error("timeout reset value wrong");

   cov_set_name: cover property (s_q.st == lnac_pkg::CS_EXEC
                                 && s_q.opc == lnac_pkg::OPC_SET_NAME);
   cov_key_wait: cover property (s_q.st == lnac_pkg::CS_WAIT ##[1:20] s_q.done);
   cov_bad_tmo:  cover property (s_q.status == lnac_pkg::ST_BAD_PARAM);
   cov_irq:      cover property ($rose(irq));
endmodule : lnac_name_tmo_ctl
`default_nettype wire

// *** rtl/lnac_pkg.sv ***
// lnac_pkg: constants and types of the local name and accept timeout command block
// Overview of operation
// - a completed key delete returns a two-byte count of the keys really removed.
// - every completed command raises a command-complete event; the mask gates only the interrupt.
// - set name, code 0x013, carries one utf-8 name in a fixed 248-byte field.
// - name bytes travel first character first, not low byte first.
// - after reset the stored name is empty, only the terminating zero byte.
// - every command returns one status byte, zero for success, else an error code.
// - read name, code 0x014, takes nothing and returns status and the stored name.
// - read timeout, code 0x015, returns status and the two-byte accept timeout.
// - write timeout, code 0x016, stores its two-byte value and answers with status.
// - the accept timeout counts baseband slots of 0.625 ms each.
// - legal timeout values run from 0x0001 to 0xb540 slots.
// - after reset the accept timeout holds 0x1fa0 slots, 5.06 seconds.
// - an incoming request not accepted when the timeout runs out is rejected.
package lnac_pkg;
   // -------------------------------------------------------------
   // timing
   // -------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned SLOT_NS       = 625000;
   localparam int unsigned SLOT_CYC      = (SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // -------------------------------------------------------------
   // commands, status codes and limits
   // -------------------------------------------------------------
   localparam logic [9:0]  OPC_DEL_KEY  = 10'h012;
   localparam logic [9:0]  OPC_SET_NAME = 10'h013;
   localparam logic [9:0]  OPC_GET_NAME = 10'h014;
   localparam logic [9:0]  OPC_GET_TMO  = 10'h015;
   localparam logic [9:0]  OPC_SET_TMO  = 10'h016;
   localparam logic [7:0]  ST_OK        = 8'h00;
   localparam logic [7:0]  ST_UNKNOWN   = 8'h01;
   localparam logic [7:0]  ST_BAD_PARAM = 8'h12;
   localparam logic [7:0]  DEL_ALL_MAX  = 8'h01;
   localparam logic [15:0] TMO_MIN      = 16'h0001;
   localparam logic [15:0] TMO_MAX      = 16'hb540;
   localparam logic [15:0] TMO_RST      = 16'h1fa0;
   localparam int unsigned NAME_LEN     = 248;
   localparam logic [7:0]  NAME_LAST    = 8'hf7;
   // -------------------------------------------------------------
   // register offsets, fields and reset values
   // -------------------------------------------------------------
   localparam logic [7:0]  REG_CMD       = 8'h00;
   localparam logic [7:0]  REG_PARAM     = 8'h04;
   localparam logic [7:0]  REG_RESULT    = 8'h08;
   localparam logic [7:0]  REG_NAME_IDX  = 8'h0c;
   localparam logic [7:0]  REG_NAME_DATA = 8'h10;
   localparam logic [7:0]  REG_TMO       = 8'h14;
   localparam logic [7:0]  REG_EVT_STAT  = 8'h18;
   localparam logic [7:0]  REG_EVT_MASK  = 8'h1c;
   localparam int unsigned RES_VAL_LSB   = 16;
   localparam int unsigned RES_BUSY_BIT  = 8;
   localparam int unsigned RES_PEND_BIT  = 9;
   localparam int unsigned EVT_DONE_BIT  = 0;
   localparam int unsigned EVT_REJ_BIT   = 1;
   localparam logic [1:0]  EVT_MASK_RST  = 2'h3;
   // -------------------------------------------------------------
   // carriers and state
   // -------------------------------------------------------------
   typedef struct packed {
      logic        read;
      logic        write;
      logic [7:0]  address;
      logic [31:0] writedata;
   } lnac_av_req_t;
   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
   } lnac_av_rsp_t;
   typedef struct packed {
      logic req;
      logic all;
   } lnac_key_req_t;
   typedef struct packed {
      logic        done;
      logic [15:0] count;
   } lnac_key_rsp_t;
   typedef enum logic [1:0] {
      CS_IDLE = 2'b00,
      CS_EXEC = 2'b01,
      CS_WAIT = 2'b11,
      CS_DONE = 2'b10
   } lnac_cmd_st_t;
endpackage : lnac_pkg

// *** testbench/lnac_key_store_model.sv ***
// lnac_key_store_model: key store that answers delete requests after a delay
`timescale 1ns/1ps
`default_nettype none
module lnac_key_store_model #(
   parameter int unsigned DLY = 3
) (
   input  wire logic                    clock,
   input  wire logic                    rst,
   input  wire lnac_pkg::lnac_key_req_t key_req,
   output var  lnac_pkg::lnac_key_rsp_t key_rsp
);
   logic [15:0] keys_q;
   logic [3:0]  cnt_q;
   logic        all_q;
   // wait a few cycles, then report how many keys really went
   always_ff @(posedge clock) begin
      key_rsp.done <= 1'b0;
      key_rsp.count <= ~key_rsp.count;  // count is junk outside done
      if (rst) begin
         keys_q <= 16'h0005;
         cnt_q <= 4'h0;
         key_rsp.count <= 16'h0;
      end else if (key_req.req) begin
         cnt_q <= DLY[3:0];
         all_q <= key_req.all;
      end else if (cnt_q == 4'h1) begin
         cnt_q <= 4'h0;
         key_rsp.done <= 1'b1;
         key_rsp.count <= all_q ? keys_q : 16'h0001;
         keys_q <= all_q ? 16'h0 : keys_q - 16'h1;
      end else if (cnt_q != 4'h0) begin
         cnt_q <= cnt_q - 4'h1;
      end
   end
endmodule : lnac_key_store_model
`default_nettype wire

// *** testbench/local_name_accept_timeout_cmds_tb_top.sv ***
// local_name_accept_timeout_cmds_tb_top: register-level regression of the command block
`timescale 1ns/1ps
`default_nettype none
module local_name_accept_timeout_cmds_tb_top;
   logic                    clock;
   logic                    rst;
   lnac_pkg::lnac_av_req_t  av_req;
   lnac_pkg::lnac_av_rsp_t  av_rsp;
   logic                    conn_req;
   logic                    conn_accept;
   logic                    conn_reject;
   lnac_pkg::lnac_key_req_t key_req;
   lnac_pkg::lnac_key_rsp_t key_rsp;
   logic                    irq;
   logic [31:0]             rdat;
   int                      error_cnt;
   int                      comparisons;
   int                      k;
   logic [15:0]             tv [4] = '{16'h0001, 16'hb540, 16'h0000, 16'hb541};

   lnac_name_tmo_ctl #(.SLOT_CYCLES(4)) dut_u (.clock(clock), .rst(rst), .av_req(av_req),
      .av_rsp(av_rsp), .conn_req(conn_req), .conn_accept(conn_accept),
      .conn_reject(conn_reject), .key_req(key_req), .key_rsp(key_rsp), .irq(irq));
   lnac_key_store_model ks_u (.clock(clock), .rst(rst), .key_req(key_req), .key_rsp(key_rsp));

   // 10 MHz clock
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   task automatic results();
      $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : results

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk

   // one avalon access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      @(posedge clock);
      av_req <= '{read: !wr, write: wr, address: a, writedata: d};
      for (n = 0; n < 20; n++) begin
         @(posedge clock);
         if (av_rsp.waitrequest === 1'b0) break;
      end
      q = av_rsp.readdata;
      av_req <= '0;
      if (n == 20) begin
         error_cnt++;
         results();
      end
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask : wr

   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] x;
      bus(1'b0, a, 32'h0, x);
      chk(x, e);
   endtask : rc

   // issue a command and poll until it is no longer busy
   task automatic cmd(input logic [9:0] c, input logic [15:0] p);
      int n;
      wr(lnac_pkg::REG_PARAM, {16'h0, p});
      wr(lnac_pkg::REG_CMD, {22'h0, c});
      for (n = 0; n < 40; n++) begin
         bus(1'b0, lnac_pkg::REG_RESULT, 32'h0, rdat);
         if (rdat[8] === 1'b0) break;
      end
      if (n == 40) begin
         error_cnt++;
         results();
      end
   endtask : cmd

   initial begin
      error_cnt = 0;
      comparisons = 0;
      rst = 1'b1;
      av_req = '0;
      conn_req = 1'b0;
      conn_accept = 1'b0;
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      rc(lnac_pkg::REG_TMO, 32'h1fa0);
      rc(lnac_pkg::REG_EVT_MASK, 32'h3);
      rc(8'h20, 32'h0);
      cmd(lnac_pkg::OPC_GET_NAME, 16'h0);
      rc(lnac_pkg::REG_NAME_DATA, 32'h0);
      cmd(10'h3ff, 16'h0);
      chk(rdat & 32'hff, 32'h01);
      $display("test reset and unknown done");
      // timeout writes at both range limits and just outside them
      for (k = 0; k < 4; k++) begin
         cmd(lnac_pkg::OPC_SET_TMO, tv[k]);
         chk(rdat & 32'hff, (k < 2) ? 32'h0 : 32'h12);
         rc(lnac_pkg::REG_TMO, (k < 2) ? {16'h0, tv[k]} : 32'hb540);
         cmd(lnac_pkg::OPC_GET_TMO, 16'h0);
         chk(rdat >> 16, (k < 2) ? {16'h0, tv[k]} : 32'hb540);
      end
      $display("test timeout range done");
      wr(lnac_pkg::REG_NAME_IDX, 32'h0);
      wr(lnac_pkg::REG_NAME_DATA, 32'h41);
      wr(lnac_pkg::REG_NAME_DATA, 32'h42);
      wr(lnac_pkg::REG_NAME_DATA, 32'h00);
      cmd(lnac_pkg::OPC_SET_NAME, 16'h0);
      chk(rdat & 32'hff, 32'h0);
      cmd(lnac_pkg::OPC_GET_NAME, 16'h0);
      rc(lnac_pkg::REG_NAME_DATA, 32'h41);
      rc(lnac_pkg::REG_NAME_DATA, 32'h42);
      rc(lnac_pkg::REG_NAME_DATA, 32'h00);
      $display("test name done");
      cmd(lnac_pkg::OPC_DEL_KEY, 16'h2);
      chk(rdat & 32'hff, 32'h12);
      cmd(lnac_pkg::OPC_DEL_KEY, 16'h0);
      chk(rdat >> 16, 32'h1);
      cmd(lnac_pkg::OPC_DEL_KEY, 16'h1);
      chk(rdat >> 16, 32'h4);
      $display("test key delete done");
      rc(lnac_pkg::REG_EVT_STAT, 32'h1);
      chk({31'h0, irq}, 32'h1);
      wr(lnac_pkg::REG_EVT_STAT, 32'h3);
      wr(lnac_pkg::REG_EVT_MASK, 32'h0);
      cmd(lnac_pkg::OPC_SET_TMO, 16'h2);
      rc(lnac_pkg::REG_EVT_STAT, 32'h1);
      chk({31'h0, irq}, 32'h0);
      wr(lnac_pkg::REG_EVT_STAT, 32'h1);
      wr(lnac_pkg::REG_EVT_MASK, 32'h3);
      $display("test events done");
      // unanswered request: reject 2 slots of 4 cycles after conn_req is taken
      @(posedge clock) conn_req <= 1'b1;
      @(posedge clock) conn_req <= 1'b0;
      for (k = 1; k < 40; k++) begin
         @(posedge clock);
         #1;
         if (conn_reject === 1'b1) break;
      end
      chk(k, 32'd8);
      rc(lnac_pkg::REG_EVT_STAT, 32'h2);
      @(posedge clock) conn_req <= 1'b1;
      @(posedge clock) conn_req <= 1'b0;
      rc(lnac_pkg::REG_RESULT, 32'h200);
      conn_accept <= 1'b1;
      @(posedge clock) conn_accept <= 1'b0;
      for (k = 0; k < 20; k++) begin
         @(posedge clock);
         #1;
         if (conn_reject === 1'b1) break;
      end
      chk(k, 32'd20);
      $display("test accept timer done");
      results();
   end
endmodule : local_name_accept_timeout_cmds_tb_top
`default_nettype wire
